// [include/ldo_regs_pkg.sv]
/*
 * Register map, field layout, reset values and voltage tables of the
 * linear regulator setpoint bank. Assumes an 8-bit register port and
 * target voltages carried as unsigned millivolts in 16 bits.
 */
package ldo_regs_pkg;

    // register offsets
    localparam logic [7:0] REG_A_OFFSET = 8'h12;
    localparam logic [7:0] REG_B_OFFSET = 8'h13;
    localparam logic [7:0] REG_C_OFFSET = 8'h14;
    localparam logic [7:0] UNLOCK_OFFSET = 8'h20;
    localparam logic [7:0] STATUS_OFFSET = 8'h21;

    // reset values and writable-bit masks
    localparam logic [7:0] REG_A_RESET = 8'h09;
    localparam logic [7:0] REG_B_RESET = 8'h38;
    localparam logic [7:0] REG_C_RESET_DEFAULT = 8'h06;
    localparam logic [7:0] REG_A_MASK = 8'h0f;
    localparam logic [7:0] REG_B_MASK = 8'h7f;
    localparam logic [7:0] REG_C_MASK = 8'h3f;
    // arbitrary value
    localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5a;

    // field positions
    localparam int TRACK_BIT = 6;
    localparam int SELECT_BIT = 5;
    localparam int STATUS_ARMED_BIT = 0;
    localparam int STATUS_REFUSED_BIT = 1;

    // regulator B code breakpoints
    localparam logic [5:0] B_FINE_LAST = 6'h17;
    localparam logic [5:0] B_COARSE_FIRST = 6'h18;
    localparam logic [5:0] B_COARSE_LAST = 6'h2f;
    localparam logic [5:0] B_TOP_FIRST = 6'h38;
    // regulator C code breakpoints
    localparam logic [4:0] C_LOW_LAST = 5'h08;
    localparam logic [4:0] C_MID_FIRST = 5'h09;
    localparam logic [4:0] C_MID_LAST = 5'h0d;
    localparam logic [4:0] C_HIGH_FIRST = 5'h10;

    localparam logic [15:0] MV_3300 = 16'd3300;

    typedef enum logic {LOCKED, ARMED} unlock_state_t;

    typedef logic [15:0] millivolt_t;

    function automatic millivolt_t reg_a_mv(input logic [3:0] code);
        case (code)
            4'h0: reg_a_mv = 16'd1000;
            4'h1: reg_a_mv = 16'd1100;
            4'h2: reg_a_mv = 16'd1200;
            4'h3: reg_a_mv = 16'd1250;
            4'h4: reg_a_mv = 16'd1300;
            4'h5: reg_a_mv = 16'd1350;
            4'h6: reg_a_mv = 16'd1400;
            4'h7: reg_a_mv = 16'd1500;
            4'h8: reg_a_mv = 16'd1600;
            4'h9: reg_a_mv = 16'd1800;
            4'ha: reg_a_mv = 16'd2500;
            4'hb: reg_a_mv = 16'd2750;
            4'hc: reg_a_mv = 16'd2800;
            4'hd: reg_a_mv = 16'd3000;
            4'he: reg_a_mv = 16'd3100;
            default: reg_a_mv = MV_3300;
        endcase
    endfunction

    function automatic millivolt_t reg_b_mv(input logic [5:0] code);
        if (code <= B_FINE_LAST)
            reg_b_mv = 16'(900 + 25 * int'(code));
        else if (code <= B_COARSE_LAST)
            reg_b_mv = 16'(1500 + 50 * int'(code - B_COARSE_FIRST));
        else if (code >= B_TOP_FIRST)
            reg_b_mv = MV_3300;
        else
        begin
            case (code[2:0])
                3'h0: reg_b_mv = 16'd2700;
                3'h1: reg_b_mv = 16'd2750;
                3'h2: reg_b_mv = 16'd2800;
                3'h3: reg_b_mv = 16'd2850;
                3'h4: reg_b_mv = 16'd2900;
                3'h5: reg_b_mv = 16'd3000;
                3'h6: reg_b_mv = 16'd3100;
                default: reg_b_mv = 16'd3200;
            endcase
        end
    endfunction

    function automatic millivolt_t reg_c_mv(input logic [4:0] code);
        if (code <= C_LOW_LAST)
            reg_c_mv = 16'(1500 + 50 * int'(code));
        else if (code <= C_MID_LAST)
            reg_c_mv = 16'(2000 + 100 * int'(code - C_MID_FIRST));
        else if (code >= C_HIGH_FIRST)
            reg_c_mv = 16'(2550 + 50 * int'(code - C_HIGH_FIRST));
        else if (code[0])
            reg_c_mv = 16'd2500;
        else
            reg_c_mv = 16'd2450;
    endfunction

endpackage

// [rtl/linear_regulator_setpoint_regs.sv]
/*
 * Password-protected setpoint bank for two linear regulators and the
 * switch-or-regulator channel, with decoded target voltages.
 * Assumes a single 100 MHz clock, a master on the plain register port
 * that never issues read and write together, and a converter setpoint
 * already expressed in millivolts.
 */
`timescale 1ns/1ps

// How it works
// [R1] regulator A register at 0x12, code in bits 3:0, resets to 0x09
// [R2] regulator A bits 7:4 read zero and ignore writes
// [R3] regulator A code decoded to target voltage by fixed table
// [R4] regulator B register at 0x13, code 5:0, track bit 6, reset 0x38
// [R5] regulator B bit 7 reads zero and ignores writes
// [R6] track clear: regulator B target comes from its own code
// [R7] track set: regulator B target follows converter setpoint, code ignored
// [R8] regulator B code: 0.9 V plus 25 mV steps up to 0x17, 3.3 V from 0x38 up
// [R9] writes to 0x12..0x14 accepted only after a correct unlock
// [R10] register at 0x14 with reset value given per device variant
// [R11] 0x14: bit 5 selects switch or regulator, code 4:0, 7:6 zero
// [R12] protected write without prior unlock leaves contents unchanged
module linear_regulator_setpoint_regs
    import ldo_regs_pkg::*;
#(
    parameter logic [7:0] REG_C_RESET = REG_C_RESET_DEFAULT,
    parameter logic [7:0] UNLOCK_KEY = UNLOCK_KEY_DEFAULT
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdata,
    input wire logic [15:0] converterCSetpointMv,
    output logic [3:0] regACode,
    output logic [15:0] regAMv,
    output logic [5:0] regBCode,
    output logic regBTrack,
    output logic [15:0] regBMv,
    output logic regCSelect,
    output logic [4:0] regCCode,
    output logic [15:0] regCMv,
    output logic unlockArmed,
    output logic writeRefused
);

    logic [7:0] regA_r;
    logic [7:0] regB_r;
    logic [7:0] regC_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [15:0] regAMv_r;
    logic [15:0] regBMv_r;
    logic [15:0] regBMv_nxt;
    logic [15:0] regCMv_r;
    logic refused_r;
    unlock_state_t state_r;
    unlock_state_t state_nxt;
    logic wrEn;
    logic rdEn;
    logic protHit;
    logic accept;

    assign wrEn = ce && wrStrobe;
    assign rdEn = ce && rdStrobe;
    assign protHit = (addr == REG_A_OFFSET) || (addr == REG_B_OFFSET) || (addr == REG_C_OFFSET);
    assign accept = wrEn && protHit && (state_r == ARMED); // [R9]

    // one write of the key arms exactly one following write of any kind other than a repeated key write, which keeps it armed
    always_comb
    begin
        state_nxt = state_r;
        if (wrEn)
        begin
            if (addr == UNLOCK_OFFSET && wdata == UNLOCK_KEY)
                state_nxt = ARMED;
            else
                state_nxt = LOCKED; // [R9]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_r <= LOCKED;
        else if (ce)
            state_r <= state_nxt;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regA_r <= REG_A_RESET; // [R1]
        else if (accept && addr == REG_A_OFFSET)
            regA_r <= wdata & REG_A_MASK; // [R1] [R2] [R12]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regB_r <= REG_B_RESET; // [R4]
        else if (accept && addr == REG_B_OFFSET)
            regB_r <= wdata & REG_B_MASK; // [R4] [R5] [R12]
    end

    // variant reset is a constant parameter, so still a constant at reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regC_r <= REG_C_RESET & REG_C_MASK; // [R10] [R11]
        else if (accept && addr == REG_C_OFFSET)
            regC_r <= wdata & REG_C_MASK; // [R11] [R12]
    end

    // sticky refusal flag; a new refusal beats a clear in the same cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            refused_r <= 1'b0;
        else if (wrEn && protHit && state_r == LOCKED)
            refused_r <= 1'b1; // [R12]
        else if (wrEn && addr == STATUS_OFFSET && wdata[STATUS_REFUSED_BIT])
            refused_r <= 1'b0;
    end

    always_comb
    begin
        rdata_nxt = 8'h00;
        case (addr)
            REG_A_OFFSET: rdata_nxt = regA_r; // [R2]
            REG_B_OFFSET: rdata_nxt = regB_r; // [R5]
            REG_C_OFFSET: rdata_nxt = regC_r; // [R11]
            STATUS_OFFSET:
            begin
                rdata_nxt[STATUS_ARMED_BIT] = (state_r == ARMED);
                rdata_nxt[STATUS_REFUSED_BIT] = refused_r;
            end
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (ce)
            rdata_r <= rdEn ? rdata_nxt : 8'h00;
    end

    always_comb
    begin
        if (regB_r[TRACK_BIT])
            regBMv_nxt = converterCSetpointMv; // [R7]
        else
            regBMv_nxt = reg_b_mv(regB_r[5:0]); // [R6] [R8]
    end

    // decoded targets lag the register by one cycle to keep outputs flopped
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            regAMv_r <= 16'h0000;
            regBMv_r <= 16'h0000;
            regCMv_r <= 16'h0000;
        end
        else if (ce)
        begin
            regAMv_r <= reg_a_mv(regA_r[3:0]); // [R3]
            regBMv_r <= regBMv_nxt;
            regCMv_r <= reg_c_mv(regC_r[4:0]);
        end
    end

    assign rdata = rdata_r;
    assign regACode = regA_r[3:0];
    assign regAMv = regAMv_r;
    assign regBCode = regB_r[5:0];
    assign regBTrack = regB_r[TRACK_BIT];
    assign regBMv = regBMv_r;
    assign regCSelect = regC_r[SELECT_BIT];
    assign regCCode = regC_r[4:0];
    assign regCMv = regCMv_r;
    assign unlockArmed = (state_r == ARMED);
    assign writeRefused = refused_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_a_reserved_zero: assert property ( // [R2]
        (rdEn && addr == REG_A_OFFSET) |=> rdata[7:4] == 4'h0)
        else $error("regulator A reserved bits read nonzero");

    chk_b_reserved_zero: assert property ( // [R5]
        (rdEn && addr == REG_B_OFFSET) |=> (rdata[7] == 1'b0 && rdata[6:0] == {regBTrack, regBCode}))
        else $error("regulator B readback wrong");

    chk_locked_write_held: assert property ( // [R12]
        (wrEn && !unlockArmed && addr == REG_A_OFFSET) |=> $stable(regACode))
        else $error("locked write changed regulator A");

    chk_armed_write_taken: assert property ( // [R9]
        (wrEn && unlockArmed && addr == REG_B_OFFSET)
            |=> {regBTrack, regBCode} == $past(wdata[6:0]))
        else $error("unlocked write to regulator B lost");

    chk_unlock_one_shot: assert property ( // [R9]
        (wrEn && unlockArmed && addr != UNLOCK_OFFSET) |=> !unlockArmed)
        else $error("unlock survived a write");

    chk_track_follow: assert property ( // [R7]
        (ce && regBTrack) |=> regBMv == $past(converterCSetpointMv))
        else $error("tracking target does not follow converter");

    chk_b_top_code: assert property ( // [R8]
        (ce && !regBTrack && regBCode >= B_TOP_FIRST) |=> regBMv == MV_3300)
        else $error("regulator B top codes not 3.3 V");

    chk_a_table_point: assert property ( // [R3]
        (ce && regACode == 4'h9) |=> regAMv == 16'd1800)
        else $error("regulator A code 9 not 1.8 V");

    chk_c_write_masked: assert property ( // [R11]
        (wrEn && unlockArmed && addr == REG_C_OFFSET)
            |=> ({regCSelect, regCCode} == $past(wdata[5:0])))
        else $error("regulator C write wrong");

    chk_c_reserved_zero: assert property ( // [R11]
        (rdEn && addr == REG_C_OFFSET) |=> (rdata == {2'b00, regCSelect, regCCode}))
        else $error("regulator C readback wrong");

    chk_ce_freeze: assert property ( // [R9]
        (!ce) |=> ($stable(unlockArmed) && $stable(regACode) && $stable(writeRefused)))
        else $error("state moved while clock enable low");

    chk_refused_sticky: assert property ( // [R12]
        (wrEn && !unlockArmed && protHit) |=> writeRefused)
        else $error("refused write not flagged");

    cov_unlock_then_write: cover property (
        (wrEn && addr == UNLOCK_OFFSET && wdata == UNLOCK_KEY) ##1 (wrEn && protHit));
    cov_tracking_on: cover property ($rose(regBTrack));
    cov_refused_write: cover property ($rose(writeRefused));
    cov_switch_to_regulator: cover property ($changed(regCSelect));

endmodule // linear_regulator_setpoint_regs

// [verif/tb_linear_regulator_setpoint_regs.sv]
/*
 * Self-checking bench for the regulator setpoint bank: an integer model of
 * the registers, unlock and voltage tables is compared at every result.
 * Assumes the plain register port with read data one cycle after the strobe.
 */
`timescale 1ns/1ps
module tb_linear_regulator_setpoint_regs
    import ldo_regs_pkg::*;
;
    logic clk, rst, ce, wrStrobe, rdStrobe, regBTrack, regCSelect, unlockArmed, writeRefused;
    logic [7:0] addr, wdata, rdata, ra, rb, rc, a;
    logic [15:0] converterCSetpointMv, regAMv, regBMv, regCMv;
    logic [3:0] regACode;
    logic [5:0] regBCode;
    logic [4:0] regCCode;
    logic [31:0] seed;
    logic unl, refd;
    int n_fail, n_tests;

    linear_regulator_setpoint_regs linear_regulator_setpoint_regs_inst (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdata(rdata), .converterCSetpointMv(converterCSetpointMv),
        .regACode(regACode), .regAMv(regAMv), .regBCode(regBCode), .regBTrack(regBTrack),
        .regBMv(regBMv), .regCSelect(regCSelect), .regCCode(regCCode), .regCMv(regCMv),
        .unlockArmed(unlockArmed), .writeRefused(writeRefused));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    function automatic logic [15:0] mvA(input logic [3:0] c);
        int t[16] = '{1000, 1100, 1200, 1250, 1300, 1350, 1400, 1500,
                      1600, 1800, 2500, 2750, 2800, 3000, 3100, 3300};
        return 16'(t[c]);
    endfunction

    function automatic logic [15:0] mvB(input logic [5:0] c);
        int t[8] = '{2700, 2750, 2800, 2850, 2900, 3000, 3100, 3200};
        if (c <= 6'd24) return 16'(900 + 25 * int'(c));
        if (c <= 6'd47) return 16'(1500 + 50 * (int'(c) - 24));
        if (c >= 6'd56) return 16'd3300;
        return 16'(t[c[2:0]]);
    endfunction

    function automatic logic [15:0] mvC(input logic [4:0] c);
        if (c <= 5'd8) return 16'(1500 + 50 * int'(c));
        if (c <= 5'd13) return 16'(2000 + 100 * (int'(c) - 9));
        if (c == 5'd14) return 16'd2450;
        if (c == 5'd15) return 16'd2500;
        return 16'(2550 + 50 * (int'(c) - 16));
    endfunction

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk);
        addr <= ad;
        wdata <= dt;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    // also checks that read data falls back to zero one cycle later
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        addr <= ad;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 chk("rdata", 16'(e), 16'(rdata));
        @(posedge clk);
        #1 chk("rdataIdle", 16'h0, 16'(rdata));
    endtask

    task automatic chkAll;
        @(posedge clk);
        #1 chk("regACode", 16'(ra[3:0]), 16'(regACode));
        chk("regAMv", mvA(ra[3:0]), regAMv);
        chk("regBCode", 16'(rb[5:0]), 16'(regBCode));
        chk("regBTrack", 16'(rb[6]), 16'(regBTrack));
        chk("regBMv", rb[6] ? converterCSetpointMv : mvB(rb[5:0]), regBMv);
        chk("regCSelect", 16'(rc[5]), 16'(regCSelect));
        chk("regCCode", 16'(rc[4:0]), 16'(regCCode));
        chk("regCMv", mvC(rc[4:0]), regCMv);
        chk("writeRefused", 16'(refd), 16'(writeRefused));
        chk("unlockArmed", 16'h0, 16'(unlockArmed));
        rd(REG_A_OFFSET, ra);
        rd(REG_B_OFFSET, rb);
        rd(REG_C_OFFSET, rc);
    endtask

    task automatic doReset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ra = 8'h09;
        rb = 8'h38;
        rc = REG_C_RESET_DEFAULT & 8'h3f;
        refd = 1'b0;
        chkAll;
    endtask

    initial
    begin
        #300000;
        n_fail++;
        end_sim;
    end

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        converterCSetpointMv = 16'd1234;
        seed = 32'd74895;
        n_fail = 0;
        n_tests = 0;
        doReset;
        wr(REG_A_OFFSET, 8'h00);
        refd = 1'b1;
        chkAll;
        // wrong key, then an unrelated write that spends the unlock
        wr(UNLOCK_OFFSET, UNLOCK_KEY_DEFAULT ^ 8'h01);
        wr(REG_B_OFFSET, 8'h00);
        wr(UNLOCK_OFFSET, UNLOCK_KEY_DEFAULT);
        wr(8'h30, 8'hff);
        wr(REG_C_OFFSET, 8'h00);
        chkAll;
        rd(8'h00, 8'h00);
        rd(8'hff, 8'h00);
        rd(STATUS_OFFSET, 8'h02);
        wr(STATUS_OFFSET, 8'h02);
        refd = 1'b0;
        repeat (60)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            converterCSetpointMv <= seed[31:16];
            unl = |seed[9:8];
            a = (seed[11:10] == 2'd3) ? REG_A_OFFSET : REG_A_OFFSET + 8'(seed[11:10]);
            if (unl)
            begin
                wr(UNLOCK_OFFSET, UNLOCK_KEY_DEFAULT);
                // a read between key and write must not spend the unlock
                if (seed[12]) rd(STATUS_OFFSET, {6'h0, refd, 1'b1});
            end
            wr(a, seed[7:0]);
            if (!unl) refd = 1'b1;
            else if (a == REG_A_OFFSET) ra = seed[7:0] & 8'h0f;
            else if (a == REG_B_OFFSET) rb = seed[7:0] & 8'h7f;
            else rc = seed[7:0] & 8'h3f;
            chkAll;
            if (refd && seed[13])
            begin
                wr(STATUS_OFFSET, 8'h02);
                refd = 1'b0;
            end
        end
        // clock enable low: key and write must both be ignored
        @(posedge clk);
        ce <= 1'b0;
        wr(UNLOCK_OFFSET, UNLOCK_KEY_DEFAULT);
        wr(REG_A_OFFSET, ~ra);
        @(posedge clk);
        ce <= 1'b1;
        chkAll;
        doReset;
        end_sim;
    end
endmodule // tb_linear_regulator_setpoint_regs
